// *** src/tefi_capture_pair.sv ***
// Notes on behaviour
// R01: Each flag reads zero until its event, then hardware sets it to one.
// R02: Interrupt request equals event flag AND its interrupt enable bit.
// R03: Flags are readable any time, independent of the enable bits.
// R04: Writing zero clears a flag; writing one leaves it unchanged.
// R05: Enable bits are plain read/write bits returning what was written.
// R06: With enable at zero a set flag raises no interrupt, polling only.
// R07: A set flag stays set until software clears it.
// R08: Service software clears the flag before returning from the interrupt.
// R09: Plain writes must carry one on every flag bit not meant to clear.
// R10: Layout: flag1 bit7, flag0 bit6, enables 5:4, edge selects 3:2 and 1:0.
// R11: The read phase of a read-modify-write returns every flag bit as one.
// R12: Alias writes read the register, replace one bit, write the whole back.
// R13: Alias zero to bit6 over 01111111 writes back 10111111.
// R14: Plain alias reads return the true, unmasked bit value.
// R15: Flags without enable bit assert their interrupt whenever set.
// R16: An event and a clearing write in one cycle leave the flag set.
`timescale 1ns/1ns
`include "tefi_cfg.svh"

module tefi_capture_pair
#(
    parameter int REG_WIDTH     = `TEFI_REG_WIDTH,
    parameter int BIT_IDX_WIDTH = `TEFI_BIT_IDX_WIDTH
)
(
    // Clock and reset.
    input  wire logic       CLK,
    input  wire logic       RESET,
    // Register port.
    input  wire logic       REG_REQ,
    input  wire logic       REG_WRITE,
    input  wire logic       REG_ALIAS,
    input  wire logic [2:0] REG_BIT,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    output logic            REG_ACK,
    output logic            REG_READY,
    // Events from the input capture unit.
    input  wire logic       CAPTURE0_EVENT,
    input  wire logic       CAPTURE1_EVENT,
    // Edge selects to the input capture unit.
    output logic      [1:0] CAPTURE0_EDGE_SELECT,
    output logic      [1:0] CAPTURE1_EDGE_SELECT,
    // Requests to the interrupt controller.
    output logic            CAPTURE0_IRQ,
    output logic            CAPTURE1_IRQ,
    // Interrupt-only flag of the waveform generator timer.
    input  wire logic       DONE_EVENT,
    input  wire logic       DONE_CLEAR,
    output logic            DONE_FLAG,
    output logic            DONE_IRQ
);

    // The register image and bit index are fixed by the field layout.
    if (REG_WIDTH != 8 || BIT_IDX_WIDTH != 3)
    begin : g_bad_width
        $error("tefi_capture_pair supports only an 8-bit register with a 3-bit index");
    end

    tefi_pkg::tefi_port_s st;
    tefi_pkg::tefi_port_s next_st;
    tefi_pkg::tefi_csr_s  csr_now;
    logic                 flag0;
    logic                 flag1;
    logic                 wr_en;
    logic [7:0]           wr_data;
    logic                 clear0;
    logic                 clear1;

    // Forces the event flag bits to one for the read phase of a read-modify-write.
    function automatic logic [7:0] mask_flags(input logic [7:0] value);
        mask_flags = value | `TEFI_FLAG_MASK; // R11
    endfunction

    // Replaces one bit of a register image.
    function automatic logic [7:0] replace_bit(input logic [7:0] value, input logic [2:0] idx, input logic b);
        logic [7:0] result;
        result = value;
        result[idx] = b;
        replace_bit = result;
    endfunction

    // Live register image with the flags as they stand.
    always_comb
    begin
        csr_now.flag1 = flag1; // R10
        csr_now.flag0 = flag0;
        csr_now.en1   = st.en1;
        csr_now.en0   = st.en0;
        csr_now.edge1 = st.edge1;
        csr_now.edge0 = st.edge0;
    end

    // A write reaches the register on a plain write or on the write-back phase.
    assign wr_en   = (st.state == tefi_pkg::TEFI_IDLE && REG_REQ && REG_WRITE && !REG_ALIAS)
                   || st.state == tefi_pkg::TEFI_RMW_WRITE; // R12
    assign wr_data = (st.state == tefi_pkg::TEFI_RMW_WRITE) ? st.rmw_data : REG_WDATA;

    // Only a zero in a flag position clears; ones written there do nothing.
    assign clear0 = wr_en && !wr_data[`TEFI_FLAG0_BIT]; // R04 R09
    assign clear1 = wr_en && !wr_data[`TEFI_FLAG1_BIT]; // R04 R09

    // Register port sequencer and the stored control fields.
    always_comb
    begin
        next_st = st;
        next_st.ack = 1'b0;
        unique case (st.state)
            tefi_pkg::TEFI_IDLE:
            begin
                if (REG_REQ && REG_WRITE && REG_ALIAS)
                begin
                    // Read phase with masked flags, then one bit replaced.
                    next_st.rmw_data = replace_bit(mask_flags(csr_now), REG_BIT, REG_WDATA[0]); // R11 R12 R13
                    next_st.rmw_bit  = REG_BIT;
                    next_st.state    = tefi_pkg::TEFI_RMW_WRITE;
                end
                else if (REG_REQ && REG_WRITE)
                begin
                    next_st.ack = 1'b1;
                end
                else if (REG_REQ && REG_ALIAS)
                begin
                    // Alias reads are not read-modify-write and stay unmasked.
                    next_st.rdata = {7'h00, csr_now[REG_BIT]}; // R14
                    next_st.ack   = 1'b1;
                end
                else if (REG_REQ)
                begin
                    next_st.rdata = csr_now; // R03 R10
                    next_st.ack   = 1'b1;
                end
            end
            tefi_pkg::TEFI_RMW_WRITE:
            begin
                next_st.ack   = 1'b1;
                next_st.state = tefi_pkg::TEFI_IDLE;
            end
        endcase
        if (wr_en)
        begin
            next_st.en1   = wr_data[`TEFI_EN1_BIT]; // R05
            next_st.en0   = wr_data[`TEFI_EN0_BIT]; // R05
            next_st.edge1 = wr_data[`TEFI_EDGE1_HI:`TEFI_EDGE1_LO];
            next_st.edge0 = wr_data[`TEFI_EDGE0_HI:`TEFI_EDGE0_LO];
        end
        next_st.ready = (next_st.state == tefi_pkg::TEFI_IDLE);
    end

    // State register.
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            st.state    <= tefi_pkg::TEFI_IDLE;
            st.en1      <= `TEFI_EN_RESET;
            st.en0      <= `TEFI_EN_RESET;
            st.edge1    <= `TEFI_EDGE_RESET;
            st.edge0    <= `TEFI_EDGE_RESET;
            st.rmw_data <= `TEFI_CSR_RESET;
            st.rmw_bit  <= 3'h0;
            st.rdata    <= `TEFI_CSR_RESET;
            st.ack      <= 1'b0;
            st.ready    <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Channel 0 capture flag and its request.
    tefi_event_flag #(.HAS_ENABLE(1'b1)) u_flag0
    (
        .clk        (CLK),
        .reset      (RESET),
        .set_event  (CAPTURE0_EVENT),
        .clear_req  (clear0),
        .irq_enable (next_st.en0),
        .flag       (flag0),
        .irq        (CAPTURE0_IRQ)
    );

    // Channel 1 capture flag and its request.
    tefi_event_flag #(.HAS_ENABLE(1'b1)) u_flag1
    (
        .clk        (CLK),
        .reset      (RESET),
        .set_event  (CAPTURE1_EVENT),
        .clear_req  (clear1),
        .irq_enable (next_st.en1),
        .flag       (flag1),
        .irq        (CAPTURE1_IRQ)
    );

    // Interrupt-only flag; it has no enable and no polling path.
    tefi_event_flag #(.HAS_ENABLE(1'b0)) u_done
    (
        .clk        (CLK),
        .reset      (RESET),
        .set_event  (DONE_EVENT),
        .clear_req  (DONE_CLEAR),
        .irq_enable (1'b1),
        .flag       (DONE_FLAG),
        .irq        (DONE_IRQ)
    );

    // Outputs straight from the state register.
    assign REG_RDATA            = st.rdata;
    assign REG_ACK              = st.ack;
    assign REG_READY            = st.ready;
    assign CAPTURE0_EDGE_SELECT = st.edge0;
    assign CAPTURE1_EDGE_SELECT = st.edge1;

    // An event sets its flag at the next edge even against a clearing write.
    flag_set_a: assert property (@(posedge CLK) disable iff (RESET) // R01 R16
        CAPTURE0_EVENT |=> flag0)
        else $error("Capture 0 event did not set its flag.");

    // A set flag stays until a zero is written to it.
    flag_sticky_a: assert property (@(posedge CLK) disable iff (RESET) // R07
        flag1 && !clear1 |=> flag1)
        else $error("Capture 1 flag dropped without a clearing write.");

    // Software cannot set a flag: without an event it stays clear.
    no_soft_set_a: assert property (@(posedge CLK) disable iff (RESET) // R04
        !flag0 && !CAPTURE0_EVENT |=> !flag0)
        else $error("Capture 0 flag set without an event.");

    // Writing zero with no event clears the flag.
    zero_clears_a: assert property (@(posedge CLK) disable iff (RESET) // R04
        clear1 && !CAPTURE1_EVENT |=> !flag1)
        else $error("Zero write did not clear capture 1 flag.");

    // Requests follow flag AND enable, and nothing else.
    irq_and_a: assert property (@(posedge CLK) disable iff (RESET) // R02 R06
        (CAPTURE0_IRQ == (flag0 && st.en0)) && (CAPTURE1_IRQ == (flag1 && st.en1)))
        else $error("Capture request differs from flag AND enable.");

    // The interrupt-only flag drives its request directly.
    done_irq_a: assert property (@(posedge CLK) disable iff (RESET) // R15
        DONE_IRQ == DONE_FLAG)
        else $error("Interrupt-only request differs from its flag.");

    // A plain read returns the live image in its documented layout.
    plain_read_a: assert property (@(posedge CLK) disable iff (RESET) // R03 R10
        st.ready && REG_REQ && !REG_WRITE && !REG_ALIAS
        |=> REG_ACK && REG_RDATA == {$past(flag1), $past(flag0), $past(st.en1), $past(st.en0),
                                     $past(st.edge1), $past(st.edge0)})
        else $error("Plain read returned a wrong image.");

    // Enable bits read back what a plain write put there.
    enable_rw_a: assert property (@(posedge CLK) disable iff (RESET) // R05
        st.ready && REG_REQ && REG_WRITE && !REG_ALIAS
        |=> {st.en1, st.en0} == $past(REG_WDATA[5:4]) && REG_ACK)
        else $error("Enable bits did not take the written value.");

    // Flags outside the target bit come back as one in the write-back image.
    rmw_mask_a: assert property (@(posedge CLK) disable iff (RESET) // R11
        st.state == tefi_pkg::TEFI_RMW_WRITE && st.rmw_bit != `TEFI_FLAG0_BIT
        && st.rmw_bit != `TEFI_FLAG1_BIT |-> st.rmw_data[7:6] == 2'h3)
        else $error("Read-modify-write image lost a flag mask.");

    // An alias write finishes in two cycles with the write-back in between.
    rmw_seq_a: assert property (@(posedge CLK) disable iff (RESET) // R12
        st.ready && REG_REQ && REG_WRITE && REG_ALIAS
        |=> !REG_READY && !REG_ACK ##1 REG_READY && REG_ACK)
        else $error("Alias write did not follow the two-cycle sequence.");

    // Zero to bit 6 over the example image writes back only bit 6 cleared.
    rmw_example_a: assert property (@(posedge CLK) disable iff (RESET) // R13
        st.ready && REG_REQ && REG_WRITE && REG_ALIAS && REG_BIT == `TEFI_FLAG0_BIT
        && !REG_WDATA[0] && csr_now == 8'h7F |=> st.rmw_data == 8'hBF)
        else $error("Alias clear of bit 6 wrote back a wrong image.");

    // The write-back never clears a flag it did not target.
    rmw_keep_a: assert property (@(posedge CLK) disable iff (RESET) // R11 R13
        st.state == tefi_pkg::TEFI_RMW_WRITE && st.rmw_bit == `TEFI_FLAG0_BIT && flag1
        |=> flag1)
        else $error("Alias write to bit 6 cleared the channel 1 flag.");

    // An alias read returns the true bit in bit 0.
    alias_read_a: assert property (@(posedge CLK) disable iff (RESET) // R14
        st.ready && REG_REQ && !REG_WRITE && REG_ALIAS
        |=> REG_ACK && REG_RDATA == {7'h00, $past(csr_now[REG_BIT])})
        else $error("Alias read returned a masked or wrong bit.");

    // The channel 0 flag also holds until a zero is written to it.
    flag0_sticky_a: assert property (@(posedge CLK) disable iff (RESET) // R07
        flag0 && !clear0 |=> flag0)
        else $error("Capture 0 flag dropped without a clearing write.");

    // Writing ones never sets the channel 1 flag without an event.
    flag1_no_set_a: assert property (@(posedge CLK) disable iff (RESET) // R04
        !flag1 && !CAPTURE1_EVENT |=> !flag1)
        else $error("Capture 1 flag set without an event.");

    // The interrupt-only event sets its flag and request even against a clear.
    done_set_a: assert property (@(posedge CLK) disable iff (RESET) // R15 R16
        DONE_EVENT |=> DONE_FLAG && DONE_IRQ)
        else $error("Interrupt-only event did not set its flag and request.");

endmodule

// *** src/tefi_cfg.svh ***
`ifndef TEFI_CFG_SVH
`define TEFI_CFG_SVH

// Width of the capture pair control and status register.
`define TEFI_REG_WIDTH      8
// Width of the bit index used by alias accesses.
`define TEFI_BIT_IDX_WIDTH  3

// Field positions inside the capture pair control and status register.
`define TEFI_FLAG1_BIT      3'h7
`define TEFI_FLAG0_BIT      3'h6
`define TEFI_EN1_BIT        3'h5
`define TEFI_EN0_BIT        3'h4
`define TEFI_EDGE1_HI       3
`define TEFI_EDGE1_LO       2
`define TEFI_EDGE0_HI       1
`define TEFI_EDGE0_LO       0

// Reset values.
`define TEFI_CSR_RESET      8'h00
`define TEFI_EDGE_RESET     2'h0
`define TEFI_EN_RESET       1'h0

// Mask that forces both event flags to one on the read phase of a read-modify-write.
`define TEFI_FLAG_MASK      8'hC0

`endif

// *** src/tefi_pkg.sv ***
package tefi_pkg;

    // Sequencer states of the register port.
    typedef enum logic [0:0]
    {
        TEFI_IDLE      = 1'b0,
        TEFI_RMW_WRITE = 1'b1
    } tefi_state_e;

    // Image of the capture pair control and status register, bit 7 first.
    typedef struct packed
    {
        logic       flag1;
        logic       flag0;
        logic       en1;
        logic       en0;
        logic [1:0] edge1;
        logic [1:0] edge0;
    } tefi_csr_s;

    // State of one event flag.
    typedef struct packed
    {
        logic flag;
        logic irq;
    } tefi_flag_s;

    // State of the register port and the stored control fields.
    typedef struct packed
    {
        tefi_state_e state;
        logic       en1;
        logic       en0;
        logic [1:0] edge1;
        logic [1:0] edge0;
        logic [7:0] rmw_data;
        logic [2:0] rmw_bit;
        logic [7:0] rdata;
        logic       ack;
        logic       ready;
    } tefi_port_s;

endpackage

// *** src/tefi_event_flag.sv ***
`timescale 1ns/1ns
`include "tefi_cfg.svh"

module tefi_event_flag
#(
    parameter bit HAS_ENABLE = 1'b1
)
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic reset,
    // Event and software access.
    input  wire logic set_event,
    input  wire logic clear_req,
    input  wire logic irq_enable,
    // Flag and request.
    output logic      flag,
    output logic      irq
);

    tefi_pkg::tefi_flag_s st;
    tefi_pkg::tefi_flag_s next_st;

    // Sticky flag: hardware sets, a zero write clears, the event wins a tie.
    always_comb
    begin
        next_st = st;
        next_st.flag = set_event | (st.flag & ~clear_req); // R01 R04 R07 R16
        if (HAS_ENABLE)
        begin
            next_st.irq = next_st.flag & irq_enable; // R02 R06
        end
        else
        begin
            next_st.irq = next_st.flag; // R15
        end
    end

    // State register.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign flag = st.flag;
    assign irq  = st.irq;

endmodule

// *** test/tefi_far_side.sv ***
`timescale 1ns/1ns

module tefi_far_side
(
    // Clock.
    input  wire logic       CLK,
    // Request from the flag logic.
    input  wire logic       IRQ0,
    // Events to the flag logic: bit 0 channel 0, bit 1 channel 1, bit 2 done.
    output logic      [2:0] EVENTS
);
    int   irq_rises = 0;
    logic irq_q     = 1'b0;

    // Counts rising request edges, as an edge-sensitive interrupt controller would.
    always @(posedge CLK)
    begin
        irq_q <= IRQ0;
        if (IRQ0 === 1'b1 && irq_q === 1'b0)
            irq_rises <= irq_rises + 1;
    end

    // Raises the chosen events for exactly one clock cycle.
    task fire(input logic [2:0] m);
    begin
        @(posedge CLK);
        EVENTS <= m;
        @(posedge CLK);
        EVENTS <= 3'h0;
    end
    endtask

    initial EVENTS = 3'h0;
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ns

module tb_top;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       req = 1'b0;
    logic       wr = 1'b0;
    logic       al = 1'b0;
    logic [2:0] bitn = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic       dclr = 1'b0;
    logic [7:0] rdata;
    logic       ack;
    logic       ready;
    logic [1:0] es0;
    logic [1:0] es1;
    logic       irq0;
    logic       irq1;
    logic       dflag;
    logic       dirq;
    logic [2:0] ev;
    logic [7:0] rd;
    int         n_fail = 0;
    int         total_checks = 0;
    int         cycles = 0;

    // Free-running bus clock, 40 ns period.
    initial forever #20 clk = ~clk;

    // Flag logic under test.
    tefi_capture_pair dut (.CLK(clk), .RESET(reset), .REG_REQ(req), .REG_WRITE(wr), .REG_ALIAS(al),
        .REG_BIT(bitn), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_ACK(ack), .REG_READY(ready),
        .CAPTURE0_EVENT(ev[0]), .CAPTURE1_EVENT(ev[1]), .CAPTURE0_EDGE_SELECT(es0),
        .CAPTURE1_EDGE_SELECT(es1), .CAPTURE0_IRQ(irq0), .CAPTURE1_IRQ(irq1), .DONE_EVENT(ev[2]),
        .DONE_CLEAR(dclr), .DONE_FLAG(dflag), .DONE_IRQ(dirq));

    // Event source and interrupt controller.
    tefi_far_side peer (.CLK(clk), .IRQ0(irq0), .EVENTS(ev));

    // Counts a comparison and reports a mismatch.
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    begin
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    end
    endtask

    // One register access; holds the request until the taking edge, then waits for the acknowledge.
    task acc(input logic w, input logic a, input logic [2:0] b, input logic [7:0] d);
        int k;
    begin
        @(posedge clk);
        req <= 1'b1;
        wr <= w;
        al <= a;
        bitn <= b;
        wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        k = 0;
        @(negedge clk);
        chk("ready", {7'h00, ~(w & a)}, {7'h00, ready});
        while (ack !== 1'b1 && k < 4)
        begin
            @(negedge clk);
            k++;
        end
        chk("ack", 8'h01, {7'h00, ack});
        chk("latency", {7'h00, w & a}, k[7:0]);
        rd = rdata;
    end
    endtask

    // Plain read compared with an expected image.
    task rchk(input logic [7:0] e);
    begin
        acc(1'b0, 1'b0, 3'h0, 8'h00);
        chk("csr", e, rd);
    end
    endtask

    // Reset values of the register and of both capture requests.
    task t_reset;
    begin
        rchk(8'h00);
        chk("irq", 8'h00, {6'h00, irq1, irq0});
    end
    endtask

    // Enables and edge selects are plain bits; writing one never sets a flag.
    task t_fields;
    begin
        acc(1'b1, 1'b0, 3'h0, 8'hFF);
        rchk(8'h3F);
        acc(1'b1, 1'b0, 3'h0, 8'hC6);
        rchk(8'h06);
        chk("edges", 8'h06, {4'h0, es1, es0});
    end
    endtask

    // Polling with enables off, then the request, then a software clear.
    task t_events;
    begin
        peer.fire(3'h1);
        rchk(8'h46);
        chk("irq0 off", 8'h00, {7'h00, irq0});
        repeat (5) @(posedge clk);
        acc(1'b1, 1'b0, 3'h0, 8'hF6);
        chk("irq0 on", 8'h01, {7'h00, irq0});
        rchk(8'h76);
        chk("rises", 8'h01, peer.irq_rises[7:0]);
        acc(1'b1, 1'b0, 3'h0, 8'hB6);
        rchk(8'h36);
        chk("irq0 cleared", 8'h00, {7'h00, irq0});
    end
    endtask

    // An event in the cycle of a clearing write wins.
    task t_collide;
    begin
        fork
            acc(1'b1, 1'b0, 3'h0, 8'hB6);
            peer.fire(3'h1);
        join
        rchk(8'h76);
    end
    endtask

    // Alias write during an event on the other flag, then alias reads.
    task t_alias;
    begin
        acc(1'b1, 1'b0, 3'h0, 8'h7F);
        rchk(8'h7F);
        fork
            acc(1'b1, 1'b1, 3'h6, 8'h00);
            peer.fire(3'h2);
        join
        rchk(8'hBF);
        chk("irq1", 8'h01, {7'h00, irq1});
        acc(1'b0, 1'b1, 3'h7, 8'h00);
        chk("alias b7", 8'h01, rd);
        acc(1'b0, 1'b1, 3'h6, 8'h00);
        chk("alias b6", 8'h00, rd);
        acc(1'b1, 1'b1, 3'h0, 8'h00);
        rchk(8'hBE);
        chk("edge0", 8'h02, {6'h00, es0});
    end
    endtask

    // Interrupt-only flag: set, held, cleared, and set winning over clear.
    task t_done;
    begin
        peer.fire(3'h4);
        repeat (3) @(negedge clk);
        chk("done", 8'h03, {6'h00, dflag, dirq});
        @(posedge clk);
        dclr <= 1'b1;
        @(posedge clk);
        dclr <= 1'b0;
        @(negedge clk);
        chk("done clr", 8'h00, {6'h00, dflag, dirq});
        fork
            peer.fire(3'h4);
            begin
                @(posedge clk);
                dclr <= 1'b1;
                @(posedge clk);
                dclr <= 1'b0;
            end
        join
        @(negedge clk);
        chk("done both", 8'h03, {6'h00, dflag, dirq});
    end
    endtask

    // Prints the counts and the verdict, then stops.
    task complete_run;
    begin
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask

    // Cuts a hang short well past the expected run length.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            complete_run();
        end
    end

    // Main sequence.
    initial
    begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_fields();
        t_events();
        t_collide();
        t_alias();
        t_done();
        complete_run();
    end
endmodule
